// file: src/pdm_channel.sv
// Function
// - Transmit count zero halts transmit movement; 1 to 65535 moves when enabled.
// - Half duplex: receive and transmit current counts share one register.
// - Receive next pointer is a 32-bit read/write register.
// - Receive next count is a 16-bit field in bits 15:0.
// - Transmit next pointer is a 32-bit read/write register.
// - Transmit next count is a 16-bit field in bits 15:0.
// - Half duplex: both next pointer views share one storage.
// - Half duplex: both next count views share one storage.
// - Writing receive-on enables receive requests unless receive-off, or in half duplex transmit-off, also written.
// - Writing receive-off disables receive requests.
// - Writing transmit-on enables transmit requests unless transmit-off, or in half duplex receive-on or receive-off, also written.
// - Writing transmit-off disables transmit requests.
// - Half duplex: enabling receive turns transmit requests off.
// - Half duplex: transmit-on acts only when receive-on is not written.
// - Half duplex: receive-off also turns transmit requests off.
// - Half duplex: transmit-off also turns receive requests off.
// - Transfer state shows receive enable in bit 0, transmit in bit 8.
// - Receive ready: request bus, read holding register, buffer, write memory.
// - Transmit ready: request bus, fetch memory, write transmit holding register.
// - Receive end flag sets at count zero; nonzero count write clears.
// - Transmit end flag sets at count zero; nonzero count write clears.
`timescale 1ns/100ps
module pdm_channel (
   input wire logic CLK_SYS,
   input wire logic SRST,
   input wire logic HALF_DUPLEX,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   input wire logic RX_READY,
   input wire logic [31:0] RX_HOLD_DATA,
   output logic RX_HOLD_RD,
   input wire logic TX_READY,
   output logic [31:0] TX_HOLD_DATA,
   output logic TX_HOLD_WR,
   output logic MEM_REQ,
   input wire logic MEM_GNT,
   output logic [31:0] MEM_ADDR,
   output logic MEM_WR,
   output logic [31:0] MEM_WDATA,
   output logic MEM_RD,
   input wire logic [31:0] MEM_RDATA,
   output logic RX_END,
   output logic TX_END,
   output logic RX_FULL,
   output logic TX_EMPTY
);
   pdm_pkg::pdm_state_t state;
   pdm_pkg::pdm_state_t next_state;
   logic [31:0] ptr [2];
   logic [15:0] cnt [2];
   logic [31:0] nptr [2];
   logic [15:0] ncnt [2];
   logic end_flag [2];
   logic full_flag [2];
   logic rx_en;
   logic tx_en;
   logic tx_phys;
   logic ctrl_wr;
   logic rx_go;
   logic tx_go;

   // Half duplex folds the transmit views onto the receive storage
   assign tx_phys = ~HALF_DUPLEX;
   assign ctrl_wr = REG_WR && (REG_ADDR == pdm_pkg::OFF_CTRL);

   assign tx_go = tx_en && (cnt[tx_phys] != pdm_pkg::RST_CNT) && TX_READY;
   assign rx_go = rx_en && (cnt[0] != pdm_pkg::RST_CNT) && RX_READY;

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         rx_en <= 1'b0;
      end else if (ctrl_wr) begin
         if (REG_WDATA[pdm_pkg::BIT_RX_OFF]) begin
            rx_en <= 1'b0;
         end else if (HALF_DUPLEX && REG_WDATA[pdm_pkg::BIT_TX_OFF]) begin
            rx_en <= 1'b0;
         end else if (REG_WDATA[pdm_pkg::BIT_RX_ON]) begin
            rx_en <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         tx_en <= 1'b0;
      end else if (ctrl_wr) begin
         if (REG_WDATA[pdm_pkg::BIT_TX_OFF]) begin
            tx_en <= 1'b0;
         end else if (HALF_DUPLEX && (REG_WDATA[pdm_pkg::BIT_RX_ON] ||
                                      REG_WDATA[pdm_pkg::BIT_RX_OFF])) begin
            tx_en <= 1'b0;
         end else if (REG_WDATA[pdm_pkg::BIT_TX_ON]) begin
            tx_en <= 1'b1;
         end
      end
   end

   // Receive wins a tie; in half duplex transmit-on leaves receive enabled, so both can be on
   always_comb begin
      next_state = state;
      case (state)
         pdm_pkg::S_IDLE: begin
            if (rx_go) begin
               next_state = pdm_pkg::S_RX_ARB;
            end else if (tx_go) begin
               next_state = pdm_pkg::S_TX_ARB;
            end
         end
         pdm_pkg::S_RX_ARB: begin
            if (!rx_en) begin
               next_state = pdm_pkg::S_IDLE;
            end else if (MEM_GNT) begin
               next_state = pdm_pkg::S_RX_READ;
            end
         end
         pdm_pkg::S_RX_READ: next_state = pdm_pkg::S_RX_STORE;
         pdm_pkg::S_RX_STORE: next_state = pdm_pkg::S_IDLE;
         pdm_pkg::S_TX_ARB: begin
            if (!tx_en) begin
               next_state = pdm_pkg::S_IDLE;
            end else if (MEM_GNT) begin
               next_state = pdm_pkg::S_TX_FETCH;
            end
         end
         pdm_pkg::S_TX_FETCH: next_state = pdm_pkg::S_TX_CAP;
         pdm_pkg::S_TX_CAP: next_state = pdm_pkg::S_TX_LOAD;
         pdm_pkg::S_TX_LOAD: next_state = pdm_pkg::S_IDLE;
         default: next_state = pdm_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state <= pdm_pkg::S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Bus is held from the request until the datum is finished
   // receive and transmit paths
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         MEM_REQ <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_RD <= 1'b0;
         RX_HOLD_RD <= 1'b0;
         TX_HOLD_WR <= 1'b0;
         MEM_ADDR <= pdm_pkg::RST_PTR;
         MEM_WDATA <= 32'h00000000;
         TX_HOLD_DATA <= 32'h00000000;
      end else begin
         MEM_REQ <= (next_state != pdm_pkg::S_IDLE);
         RX_HOLD_RD <= (next_state == pdm_pkg::S_RX_READ);
         MEM_WR <= (next_state == pdm_pkg::S_RX_STORE);
         MEM_RD <= (next_state == pdm_pkg::S_TX_FETCH);
         TX_HOLD_WR <= (next_state == pdm_pkg::S_TX_LOAD);
         if (state == pdm_pkg::S_RX_READ) begin
            MEM_WDATA <= RX_HOLD_DATA;
            MEM_ADDR <= ptr[0];
         end
         if (next_state == pdm_pkg::S_TX_FETCH) begin
            MEM_ADDR <= ptr[tx_phys];
         end
         if (state == pdm_pkg::S_TX_CAP) begin
            TX_HOLD_DATA <= MEM_RDATA;
         end
      end
   end

   // One storage set per physical channel; set 1 idles in half duplex
   for (genvar c = 0; c < 2; c++) begin : gen_ch
      localparam logic CH = 1'(c);
      logic done;
      logic w_ptr;
      logic w_cnt;
      logic w_nptr;
      logic w_ncnt;
      logic nz;
      assign done = ((state == pdm_pkg::S_RX_STORE) && (CH == 1'b0)) ||
                    ((state == pdm_pkg::S_TX_LOAD) && (tx_phys == CH));
      assign w_ptr = REG_WR &&
         (((REG_ADDR == pdm_pkg::OFF_RX_PTR) && (CH == 1'b0)) ||
          ((REG_ADDR == pdm_pkg::OFF_TX_PTR) && (tx_phys == CH)));
      assign w_cnt = REG_WR &&
         (((REG_ADDR == pdm_pkg::OFF_RX_CNT) && (CH == 1'b0)) ||
          ((REG_ADDR == pdm_pkg::OFF_TX_CNT) && (tx_phys == CH)));
      assign w_nptr = REG_WR &&
         (((REG_ADDR == pdm_pkg::OFF_RX_NPTR) && (CH == 1'b0)) ||
          ((REG_ADDR == pdm_pkg::OFF_TX_NPTR) && (tx_phys == CH)));
      assign w_ncnt = REG_WR &&
         (((REG_ADDR == pdm_pkg::OFF_RX_NCNT) && (CH == 1'b0)) ||
          ((REG_ADDR == pdm_pkg::OFF_TX_NCNT) && (tx_phys == CH)));
      assign nz = (REG_WDATA[15:0] != pdm_pkg::RST_CNT);

      always_ff @(posedge CLK_SYS) begin
         if (SRST) begin
            nptr[c] <= pdm_pkg::RST_PTR;
         end else if (w_nptr) begin
            nptr[c] <= REG_WDATA;
         end
      end

      // Software writes win over the transfer in the same cycle
      // reload from next
      always_ff @(posedge CLK_SYS) begin
         if (SRST) begin
            ptr[c] <= pdm_pkg::RST_PTR;
            cnt[c] <= pdm_pkg::RST_CNT;
            ncnt[c] <= pdm_pkg::RST_CNT;
         end else begin
            if (w_ptr) begin
               ptr[c] <= REG_WDATA;
            end else if (done) begin
               ptr[c] <= ptr[c] + pdm_pkg::ADDR_STEP;
            end else if (cnt[c] == pdm_pkg::RST_CNT &&
                         ncnt[c] != pdm_pkg::RST_CNT && !w_cnt) begin
               ptr[c] <= nptr[c];
            end
            if (w_cnt) begin
               cnt[c] <= REG_WDATA[15:0];
            end else if (done) begin
               cnt[c] <= cnt[c] - 16'h0001;
            end else if (cnt[c] == pdm_pkg::RST_CNT && !w_ncnt &&
                         ncnt[c] != pdm_pkg::RST_CNT) begin
               cnt[c] <= ncnt[c];
            end
            if (w_ncnt) begin
               ncnt[c] <= REG_WDATA[15:0];
            end else if (!done && !w_cnt && cnt[c] == pdm_pkg::RST_CNT &&
                         ncnt[c] != pdm_pkg::RST_CNT) begin
               ncnt[c] <= pdm_pkg::RST_CNT;
            end
         end
      end

      // Set wins over a clearing write in the same cycle
      // receive or transmit end
      always_ff @(posedge CLK_SYS) begin
         if (SRST) begin
            end_flag[c] <= 1'b0;
            full_flag[c] <= 1'b0;
         end else if (done && cnt[c] == 16'h0001) begin
            end_flag[c] <= 1'b1;
            full_flag[c] <= (ncnt[c] == pdm_pkg::RST_CNT);
         end else if ((w_cnt || w_ncnt) && nz) begin
            end_flag[c] <= 1'b0;
            full_flag[c] <= 1'b0;
         end
      end
   end

   // Flags reach the peripheral one cycle after they change
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RX_END <= 1'b0;
         TX_END <= 1'b0;
         RX_FULL <= 1'b0;
         TX_EMPTY <= 1'b0;
      end else begin
         RX_END <= end_flag[0];
         TX_END <= end_flag[tx_phys];
         RX_FULL <= full_flag[0];
         TX_EMPTY <= full_flag[tx_phys];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST || !REG_RD) begin
         REG_RDATA <= 32'h00000000;
      end else begin
         case (REG_ADDR)
            pdm_pkg::OFF_RX_PTR: REG_RDATA <= ptr[0];
            pdm_pkg::OFF_RX_CNT: REG_RDATA <= {16'h0000, cnt[0]};
            pdm_pkg::OFF_TX_PTR: REG_RDATA <= ptr[tx_phys];
            pdm_pkg::OFF_TX_CNT: REG_RDATA <= {16'h0000, cnt[tx_phys]};
            pdm_pkg::OFF_RX_NPTR: REG_RDATA <= nptr[0];
            pdm_pkg::OFF_RX_NCNT: REG_RDATA <= {16'h0000, ncnt[0]};
            pdm_pkg::OFF_TX_NPTR: REG_RDATA <= nptr[tx_phys];
            pdm_pkg::OFF_TX_NCNT: REG_RDATA <= {16'h0000, ncnt[tx_phys]};
            pdm_pkg::OFF_STATE: REG_RDATA <= {23'h000000, tx_en, 7'h00, rx_en};
            default: REG_RDATA <= 32'h00000000;
         endcase
      end
   end

   default clocking dflt_cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   AST_TX_ZERO_HALT: assert property (
      (state == pdm_pkg::S_IDLE && cnt[tx_phys] == pdm_pkg::RST_CNT && !rx_go)
      |=> state == pdm_pkg::S_IDLE)
      else $error("transmit moved with zero count");
   AST_HALF_CNT_SHARED: assert property (
      (HALF_DUPLEX && REG_WR && REG_ADDR == pdm_pkg::OFF_TX_CNT)
      |=> cnt[0] == $past(REG_WDATA[15:0]))
      else $error("half duplex count not shared");
   AST_HALF_NPTR_VIEW: assert property (
      (HALF_DUPLEX && REG_RD && REG_ADDR == pdm_pkg::OFF_TX_NPTR)
      |=> REG_RDATA == $past(nptr[0]))
      else $error("transmit next pointer view differs");
   AST_RX_ON: assert property (
      (ctrl_wr && REG_WDATA[0] && !REG_WDATA[1] &&
       !(HALF_DUPLEX && REG_WDATA[9])) |=>
      rx_en ##1 (rx_en || $past(ctrl_wr)))
      else $error("receive enable not taken");
   AST_RX_OFF: assert property (
      (ctrl_wr && REG_WDATA[1]) |=> !rx_en)
      else $error("receive disable not taken");
   AST_TX_OFF: assert property (
      (ctrl_wr && REG_WDATA[9]) |=> !tx_en)
      else $error("transmit disable not taken");
   AST_TX_OFF_NO_START: assert property (
      (state == pdm_pkg::S_IDLE && !tx_en) |=> state != pdm_pkg::S_TX_ARB)
      else $error("transmit started while disabled");
   AST_HALF_RX_ON_TX_OFF: assert property (
      (HALF_DUPLEX && ctrl_wr && REG_WDATA[0]) |=> !tx_en)
      else $error("half duplex transmit left on");
   AST_HALF_TX_OFF_RX: assert property (
      (HALF_DUPLEX && ctrl_wr && REG_WDATA[9]) |=> !rx_en)
      else $error("half duplex receive left on");
   AST_STATE_READ: assert property (
      (REG_RD && REG_ADDR == pdm_pkg::OFF_STATE) |=>
      REG_RDATA == {23'h000000, $past(tx_en), 7'h00, $past(rx_en)})
      else $error("transfer state read wrong");
   AST_RX_PATH: assert property (
      (state == pdm_pkg::S_RX_ARB && MEM_GNT && rx_en) |=> RX_HOLD_RD
      ##1 (MEM_WR && MEM_REQ && MEM_WDATA == $past(RX_HOLD_DATA)))
      else $error("receive datum not stored");
   AST_TX_PATH: assert property (
      (state == pdm_pkg::S_TX_ARB && MEM_GNT && tx_en) |=> MEM_RD ##2
      (TX_HOLD_WR && TX_HOLD_DATA == $past(MEM_RDATA)))
      else $error("transmit datum not loaded");
   AST_RX_END: assert property (
      (state == pdm_pkg::S_RX_STORE && cnt[0] == 16'h0001) |=> end_flag[0]
      ##1 RX_END)
      else $error("receive end missed");
   AST_ADVANCE: assert property (
      (state == pdm_pkg::S_RX_STORE && !REG_WR) |=>
      cnt[0] == $past(cnt[0]) - 16'h0001 &&
      ptr[0] == $past(ptr[0]) + pdm_pkg::ADDR_STEP)
      else $error("pointer or count not advanced");
   AST_RELOAD: assert property (
      (cnt[0] == pdm_pkg::RST_CNT && ncnt[0] != pdm_pkg::RST_CNT &&
       state != pdm_pkg::S_RX_STORE && !REG_WR) |=>
      cnt[0] == $past(ncnt[0]) && ncnt[0] == pdm_pkg::RST_CNT)
      else $error("next buffer not loaded");

   COV_RX_DATUM: cover property (state == pdm_pkg::S_RX_STORE);
   COV_TX_DATUM: cover property (state == pdm_pkg::S_TX_LOAD);
   COV_RELOAD: cover property (
      cnt[0] == pdm_pkg::RST_CNT && ncnt[0] != pdm_pkg::RST_CNT
      ##1 cnt[0] != pdm_pkg::RST_CNT);
   COV_HALF_TX: cover property (HALF_DUPLEX && TX_HOLD_WR);
endmodule

// file: src/pdm_pkg.sv
package pdm_pkg;
   // Register byte offsets, one aligned word each
   localparam logic [7:0] OFF_RX_PTR = 8'h00;
   localparam logic [7:0] OFF_RX_CNT = 8'h04;
   localparam logic [7:0] OFF_TX_PTR = 8'h08;
   localparam logic [7:0] OFF_TX_CNT = 8'h0C;
   localparam logic [7:0] OFF_RX_NPTR = 8'h10;
   localparam logic [7:0] OFF_RX_NCNT = 8'h14;
   localparam logic [7:0] OFF_TX_NPTR = 8'h18;
   localparam logic [7:0] OFF_TX_NCNT = 8'h1C;
   localparam logic [7:0] OFF_CTRL = 8'h20;
   localparam logic [7:0] OFF_STATE = 8'h24;

   // Transfer control and transfer state bit positions
   localparam int BIT_RX_ON = 0;
   localparam int BIT_RX_OFF = 1;
   localparam int BIT_TX_ON = 8;
   localparam int BIT_TX_OFF = 9;

   localparam int CNT_W = 16;

   // Reset values
   localparam logic [31:0] RST_PTR = 32'h00000000;
   localparam logic [15:0] RST_CNT = 16'h0000;

   // Pointer advance per datum, in bytes (word transfers)
   localparam logic [31:0] ADDR_STEP = 32'h00000004;

   typedef enum logic [2:0] {
      S_IDLE,
      S_RX_ARB,
      S_RX_READ,
      S_RX_STORE,
      S_TX_ARB,
      S_TX_FETCH,
      S_TX_CAP,
      S_TX_LOAD
   } pdm_state_t;
endpackage

// file: tb/pdm_periph_model.sv
`timescale 1ns/100ps
module pdm_periph_model (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic rx_go,
   input wire logic tx_go,
   input wire logic slow,
   output logic rx_ready,
   output logic [31:0] rx_hold_data,
   input wire logic rx_hold_rd,
   output logic tx_ready,
   input wire logic [31:0] tx_hold_data,
   input wire logic tx_hold_wr,
   input wire logic mem_req,
   output logic mem_gnt,
   input wire logic [31:0] mem_addr,
   input wire logic mem_wr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_rd,
   output logic [31:0] mem_rdata
);
   localparam logic [31:0] MIX = 32'h5A5A0000;
   logic [31:0] rx_word;
   logic [31:0] rd_addr;
   logic rd_dly;
   logic [1:0] gnt_wait;
   int mw_n;
   int th_n;
   logic [31:0] mw_addr [16];
   logic [31:0] mw_data [16];
   logic [31:0] th_data [16];

   assign rx_ready = rx_go;
   assign tx_ready = tx_go;
   // Word only valid while ready, so a late read sees a changed value
   assign rx_hold_data = rx_go ? rx_word : ~rx_word;
   // Slow mode makes the request wait three cycles, then holds the grant
   assign mem_gnt = mem_req && (!slow || gnt_wait == 2'h3);
   assign mem_rdata = rd_dly ? (rd_addr ^ MIX) : ~(rd_addr ^ MIX);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         gnt_wait <= 2'h0;
         rd_dly <= 1'b0;
         rx_word <= 32'hC0DE0000;
         mw_n <= 0;
         th_n <= 0;
      end else begin
         gnt_wait <= !mem_req ? 2'h0 : (gnt_wait == 2'h3 ? 2'h3 : gnt_wait + 2'h1);
         rd_dly <= mem_rd;
         rd_addr <= mem_addr;
         if (rx_hold_rd) begin
            rx_word <= rx_word + 32'h00000001;
         end
         if (mem_wr) begin
            mw_addr[mw_n[3:0]] <= mem_addr;
            mw_data[mw_n[3:0]] <= mem_wdata;
            mw_n <= mw_n + 1;
         end
         if (tx_hold_wr) begin
            th_data[th_n[3:0]] <= tx_hold_data;
            th_n <= th_n + 1;
         end
      end
   end
endmodule

// file: tb/peripheral_dma_channel_control_tb.sv
`timescale 1ns/100ps
module peripheral_dma_channel_control_tb;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic half_duplex = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rx_go = 1'b0;
   logic tx_go = 1'b0;
   logic slow = 1'b0;
   logic [31:0] reg_rdata, rx_hold_data, tx_hold_data;
   logic [31:0] mem_addr, mem_wdata, mem_rdata;
   logic rx_ready, rx_hold_rd, tx_ready, tx_hold_wr;
   logic mem_req, mem_gnt, mem_wr, mem_rd;
   logic rx_end, tx_end, rx_full, tx_empty;
   int bad_count = 0;
   int comparisons = 0;

   always #20 clk_sys = ~clk_sys;

   pdm_channel dut_u (
      .CLK_SYS(clk_sys), .SRST(srst), .HALF_DUPLEX(half_duplex),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_READY(rx_ready),
      .RX_HOLD_DATA(rx_hold_data), .RX_HOLD_RD(rx_hold_rd),
      .TX_READY(tx_ready), .TX_HOLD_DATA(tx_hold_data),
      .TX_HOLD_WR(tx_hold_wr), .MEM_REQ(mem_req), .MEM_GNT(mem_gnt),
      .MEM_ADDR(mem_addr), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata),
      .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .RX_END(rx_end),
      .TX_END(tx_end), .RX_FULL(rx_full), .TX_EMPTY(tx_empty)
   );

   pdm_periph_model model_u (
      .clk_sys, .srst, .rx_go, .tx_go, .slow, .rx_ready, .rx_hold_data,
      .rx_hold_rd, .tx_ready, .tx_hold_data, .tx_hold_wr, .mem_req,
      .mem_gnt, .mem_addr, .mem_wr, .mem_wdata, .mem_rd, .mem_rdata
   );

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      chk($sformatf("register %h", a), reg_rdata, exp);
   endtask

   task automatic ctl(input logic [31:0] cmd, input logic [31:0] exp);
      wr(pdm_pkg::OFF_CTRL, cmd);
      rd(pdm_pkg::OFF_STATE, exp);
   endtask

   task automatic wait_for(input bit tx, input int n);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge clk_sys);
         if ((tx ? model_u.th_n : model_u.mw_n) >= n) break;
      end
      if (i == 300) begin
         bad_count++;
         $display("ERROR transfer count expected %0d seen timeout", n);
         end_sim();
      end
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
   endtask

   initial begin
      do_reset();
      // Whole map reads zero after reset, unmapped word included
      for (int a = 0; a <= 40; a += 4) begin
         rd(a[7:0], 32'h00000000);
      end
      // Nonzero current counts keep the next values from reloading
      wr(pdm_pkg::OFF_RX_CNT, 32'h00000001);
      wr(pdm_pkg::OFF_TX_CNT, 32'h00000001);
      wr(pdm_pkg::OFF_RX_NPTR, 32'hFFFFFFFF);
      rd(pdm_pkg::OFF_RX_NPTR, 32'hFFFFFFFF);
      wr(pdm_pkg::OFF_RX_NCNT, 32'hFFFFFFFF);
      rd(pdm_pkg::OFF_RX_NCNT, 32'h0000FFFF);
      wr(pdm_pkg::OFF_TX_NPTR, 32'h12345678);
      rd(pdm_pkg::OFF_TX_NPTR, 32'h12345678);
      wr(pdm_pkg::OFF_TX_NCNT, 32'h0001ABCD);
      rd(pdm_pkg::OFF_TX_NCNT, 32'h0000ABCD);
      rd(pdm_pkg::OFF_CTRL, 32'h00000000);
      ctl(32'h00000001, 32'h00000001);
      ctl(32'h00000000, 32'h00000001);
      ctl(32'h00000100, 32'h00000101);
      ctl(32'h00000002, 32'h00000100);
      ctl(32'h00000003, 32'h00000100);
      ctl(32'h00000200, 32'h00000000);
      wr(pdm_pkg::OFF_STATE, 32'hFFFFFFFF);
      rd(pdm_pkg::OFF_STATE, 32'h00000000);
      // Two received words with a slow grant
      wr(pdm_pkg::OFF_RX_NCNT, 32'h00000000);
      wr(pdm_pkg::OFF_TX_NCNT, 32'h00000000);
      wr(pdm_pkg::OFF_TX_CNT, 32'h00000000);
      wr(pdm_pkg::OFF_RX_PTR, 32'h00001000);
      wr(pdm_pkg::OFF_RX_CNT, 32'h00000002);
      rx_go <= 1'b1;
      slow <= 1'b1;
      ctl(32'h00000001, 32'h00000001);
      wait_for(1'b0, 2);
      @(posedge clk_sys);
      rx_go <= 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("rx addr 0", model_u.mw_addr[0], 32'h00001000);
      chk("rx addr 1", model_u.mw_addr[1], 32'h00001004);
      chk("rx data 0", model_u.mw_data[0], 32'hC0DE0000);
      chk("rx data 1", model_u.mw_data[1], 32'hC0DE0001);
      chk("rx end", {31'h0, rx_end}, 32'h00000001);
      chk("rx full", {31'h0, rx_full}, 32'h00000001);
      chk("mem req idle", {31'h0, mem_req}, 32'h00000000);
      rd(pdm_pkg::OFF_RX_PTR, 32'h00001008);
      rd(pdm_pkg::OFF_RX_CNT, 32'h00000000);
      wr(pdm_pkg::OFF_RX_CNT, 32'h00000001);
      repeat (2) @(negedge clk_sys);
      chk("rx end cleared", {31'h0, rx_end}, 32'h00000000);
      ctl(32'h00000002, 32'h00000000);
      // One transmit word, then a reload from the next buffer
      wr(pdm_pkg::OFF_TX_PTR, 32'h00002000);
      wr(pdm_pkg::OFF_TX_CNT, 32'h00000001);
      wr(pdm_pkg::OFF_TX_NPTR, 32'h00003000);
      wr(pdm_pkg::OFF_TX_NCNT, 32'h00000001);
      slow <= 1'b0;
      tx_go <= 1'b1;
      ctl(32'h00000100, 32'h00000100);
      wait_for(1'b1, 2);
      repeat (20) @(negedge clk_sys);
      chk("tx words", 32'(model_u.th_n), 32'h00000002);
      chk("tx data 0", model_u.th_data[0], 32'h5A5A2000);
      chk("tx data 1", model_u.th_data[1], 32'h5A5A3000);
      chk("tx end", {31'h0, tx_end}, 32'h00000001);
      chk("tx empty", {31'h0, tx_empty}, 32'h00000001);
      rd(pdm_pkg::OFF_TX_PTR, 32'h00003004);
      rd(pdm_pkg::OFF_TX_NCNT, 32'h00000000);
      @(posedge clk_sys);
      tx_go <= 1'b0;
      ctl(32'h00000200, 32'h00000000);
      // Half duplex folds both views onto shared storage
      @(posedge clk_sys);
      half_duplex <= 1'b1;
      do_reset();
      wr(pdm_pkg::OFF_RX_CNT, 32'h00000007);
      rd(pdm_pkg::OFF_TX_CNT, 32'h00000007);
      wr(pdm_pkg::OFF_TX_CNT, 32'h00000005);
      rd(pdm_pkg::OFF_RX_CNT, 32'h00000005);
      wr(pdm_pkg::OFF_TX_NPTR, 32'hABCD0000);
      rd(pdm_pkg::OFF_RX_NPTR, 32'hABCD0000);
      rd(pdm_pkg::OFF_TX_NPTR, 32'hABCD0000);
      wr(pdm_pkg::OFF_RX_NCNT, 32'h00000003);
      rd(pdm_pkg::OFF_TX_NCNT, 32'h00000003);
      // Emptying the current count pulls in the next buffer
      wr(pdm_pkg::OFF_RX_CNT, 32'h00000000);
      rd(pdm_pkg::OFF_TX_CNT, 32'h00000003);
      rd(pdm_pkg::OFF_TX_PTR, 32'hABCD0000);
      rd(pdm_pkg::OFF_RX_NCNT, 32'h00000000);
      ctl(32'h00000100, 32'h00000100);
      ctl(32'h00000001, 32'h00000001);
      ctl(32'h00000200, 32'h00000000);
      ctl(32'h00000001, 32'h00000001);
      ctl(32'h00000002, 32'h00000000);
      end_sim();
   end
endmodule
